// ### hdl/i2c_slave_regs.svh
// register offsets, field positions, reset values and codes of the i2c slave
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define OFS_MODE_CTRL     8'h00
`define OFS_STATUS        8'h04
`define OFS_SHIFT_DATA    8'h08
`define OFS_OWN_ADDR      8'h0C
`define OFS_TIMEOUT       8'h10

// ************************************************************
// fields of serial_mode_control
// ************************************************************
`define MODE_HI           7
`define MODE_LO           5
`define DEB_HI            3
`define DEB_LO            2
`define BIT_MODULE_ON     1
`define BIT_SPI_PARTIAL   0

// ************************************************************
// fields of bus_status_flags
// ************************************************************
`define BIT_XFER_DONE     7
`define BIT_ADDR_HIT      6
`define BIT_BUS_BUSY      5
`define BIT_TX_SELECT     4
`define BIT_ACK_OUT       3
`define BIT_HOST_READ     2
`define BIT_WAKE_EN       1
`define BIT_ACK_IN        0

// ************************************************************
// fields of bus_timeout_control
// ************************************************************
`define BIT_TIMEOUT_ON    7
`define BIT_TIMEOUT_FLAG  6

// ************************************************************
// reset values and codes
// ************************************************************
`define RST_MODE          3'h7
`define RST_OWN_ADDR      8'h00
`define MODE_I2C_SLAVE    3'h6
`define DEB_LEN_NONE      3'h0
`define DEB_LEN_TWO       3'h2
`define DEB_LEN_FOUR      3'h4
`define BYTE_BITS         4'h8

`endif

// ### hdl/i2c_slave_pkg.sv
// types shared by the i2c slave files
package i2c_slave_pkg;

  // link states of the slave engine
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_rx,
    st_rx_ack,
    st_tx,
    st_tx_ack,
    st_wait_stop
  } link_state_type;

  typedef logic [2:0] op_mode_type;

endpackage : i2c_slave_pkg

// ### hdl/clean_line_filter.sv
// debounce filter for one bus line, length in system clocks
`timescale 1ns/1ps
`default_nettype none
module clean_line_filter #(
  parameter int MAX_LEN = 4
) (
  input  wire logic       pclk,     // system clock
  input  wire logic       presetn,  // async reset, active low
  input  wire logic       line_in,  // raw bus line
  input  wire logic [2:0] len,      // stable cycles needed, 0 = none
  output var  logic       line_out  // filtered line
);

  logic [2:0] cnt;

  // a change passes only once it has held for len clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt      <= 3'h0;
      line_out <= 1'b1;
    end
    else if (line_in == line_out)
      cnt <= 3'h0;
    else if (cnt + 3'h1 >= len)
    begin
      line_out <= line_in;
      cnt      <= 3'h0;
    end
    else
      cnt <= cnt + 3'h1;
  end

endmodule : clean_line_filter
`default_nettype wire

// ### hdl/bus_cond_detect.sv
// edge, start and stop detection on filtered scl and sda
`timescale 1ns/1ps
`default_nettype none
module bus_cond_detect (
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, active low
  input  wire logic scl_f,    // filtered scl
  input  wire logic sda_f,    // filtered sda
  output var  logic scl_rise, // scl rose
  output var  logic scl_fall, // scl fell
  output var  logic start_det,// sda fell, scl high
  output var  logic stop_det  // sda rose, scl high
);

  logic scl_prev;
  logic sda_prev;

  // previous sample of both lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  // both lines are filtered alike so data edges never look like start/stop
  assign scl_rise  = scl_f & ~scl_prev;
  assign scl_fall  = ~scl_f & scl_prev;
  assign start_det = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_det  = scl_f & scl_prev & ~sda_prev & sda_f;

endmodule : bus_cond_detect
`default_nettype wire

// ### hdl/serial_module_i2c_slave.sv
// i2c slave function of the serial module with its apb register file
//
// Behaviour
// - slave only; master owns the bus
// - scl glitches filtered with system clocks
// - filter length two or four clocks
// - one data register carries all bytes
// - own address bits 7..1, bit 0 free
// - selected when address equals own address
// - mode field decodes; 110 is i2c slave
// - debounce field 00 none, 01 two, 1x four
// - disabled module releases both lines
// - enable rise keeps tx select, ack out
// - enable rise restores flag defaults
// - bit 0 spi partial flag, no effect
// - status register reports link state
// - timeout register: enable, flag, period
// - address match sets hit, raises event
// - eighth address bit gives direction
// - ninth clock ack clears ack flag
// - start condition sets bus busy
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "i2c_slave_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_module_i2c_slave (
  input  wire logic                      pclk,      // system clock, 10 MHz
  input  wire logic                      presetn,   // async reset, active low
  input  wire logic                      psel,      // apb select
  input  wire logic                      penable,   // apb access phase
  input  wire logic                      pwrite,    // apb direction
  input  wire logic [7:0]                paddr,     // apb byte address
  input  wire logic [31:0]               pwdata,    // apb write data
  output var  logic [31:0]               prdata,    // apb read data
  output var  logic                      pready,    // apb ready
  output var  logic                      pslverr,   // apb error
  input  wire logic                      scl_in,    // scl pin level
  output var  logic                      scl_out,   // scl drive value
  output var  logic                      scl_oe_n,  // scl enable, low drives
  input  wire logic                      sda_in,    // sda pin level
  output var  logic                      sda_out,   // sda drive value
  output var  logic                      sda_oe_n,  // sda enable, low drives
  output var  logic                      sim_event, // match or byte done pulse
  output var  i2c_slave_pkg::op_mode_type op_mode   // current mode field
);
  import i2c_slave_pkg::*;

  // ************************************************************
  // register state
  // ************************************************************
  logic [1:0]     glitch_filter_sel;
  logic           module_on;
  logic           spi_partial_flag;
  logic           xfer_done_flag;
  logic           addr_hit_flag;
  logic           bus_busy_flag;
  logic           slave_tx_select;
  logic           ack_out_ctrl;
  logic           host_read_flag;
  logic           addr_wake_en;
  logic           ack_in_flag;
  logic [7:0]     shift_data;
  logic [7:0]     own_slave_address;
  logic [7:0]     bus_timeout_control;
  logic           on_prev;
  link_state_type state;
  logic [7:0]     shreg;
  logic [3:0]     bit_cnt;
  logic [2:0]     deb_len;
  logic           scl_f;
  logic           sda_f;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic wr;
  logic rd_setup;
  logic mapped;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = paddr == `OFS_MODE_CTRL || paddr == `OFS_STATUS ||
                    paddr == `OFS_SHIFT_DATA || paddr == `OFS_OWN_ADDR ||
                    paddr == `OFS_TIMEOUT;
  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic wr_mode;
  logic wr_stat;
  logic wr_data;
  assign wr_mode = wr && paddr == `OFS_MODE_CTRL;
  assign wr_stat = wr && paddr == `OFS_STATUS;
  assign wr_data = wr && paddr == `OFS_SHIFT_DATA;

  // ************************************************************
  // mode and line conditioning
  // ************************************************************
  logic active;
  logic on_rise;
  // i2c engine runs only in mode 110 with the module on
  assign active  = module_on && op_mode == `MODE_I2C_SLAVE;
  assign on_rise = module_on & ~on_prev;

  // debounce length: only meaningful in i2c mode
  assign deb_len = glitch_filter_sel[1] ? `DEB_LEN_FOUR :
                   glitch_filter_sel[0] ? `DEB_LEN_TWO : `DEB_LEN_NONE;

  // sda shares the scl filter length so edges keep their order
  clean_line_filter #(.MAX_LEN(4)) u_scl_filt (
    .pclk     (pclk),
    .presetn  (presetn),
    .line_in  (scl_in),
    .len      (deb_len),
    .line_out (scl_f)
  );
  clean_line_filter #(.MAX_LEN(4)) u_sda_filt (
    .pclk     (pclk),
    .presetn  (presetn),
    .line_in  (sda_in),
    .len      (deb_len),
    .line_out (sda_f)
  );
  bus_cond_detect u_cond (
    .pclk      (pclk),
    .presetn   (presetn),
    .scl_f     (scl_f),
    .sda_f     (sda_f),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ************************************************************
  // engine events
  // ************************************************************
  logic addr_done;
  logic match;
  logic rx_done;
  logic tx_done;
  logic ack_rise;
  logic byte_begin;
  assign addr_done  = active && state == st_addr && scl_fall && bit_cnt == `BYTE_BITS;
  assign match      = addr_done && shreg[7:1] == own_slave_address[7:1];
  assign rx_done    = active && state == st_rx && scl_fall && bit_cnt == `BYTE_BITS;
  assign tx_done    = active && state == st_tx && scl_fall && bit_cnt == 4'h7;
  assign ack_rise   = active && state == st_tx_ack && scl_rise;
  assign byte_begin = active && scl_rise && bit_cnt == 4'h0 &&
                      (state == st_addr || state == st_rx || state == st_tx);

  // ************************************************************
  // control registers written by software
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_mode             <= `RST_MODE;
      glitch_filter_sel   <= 2'h0;
      module_on           <= 1'b0;
      spi_partial_flag    <= 1'b0;
      slave_tx_select     <= 1'b0;
      ack_out_ctrl        <= 1'b0;
      addr_wake_en        <= 1'b0;
      own_slave_address   <= `RST_OWN_ADDR;
      bus_timeout_control <= 8'h00;
      on_prev             <= 1'b0;
    end
    else
    begin
      on_prev <= module_on;
      if (wr_mode)
      begin
        op_mode           <= pwdata[`MODE_HI:`MODE_LO];
        glitch_filter_sel <= pwdata[`DEB_HI:`DEB_LO];
        module_on         <= pwdata[`BIT_MODULE_ON];
        spi_partial_flag  <= pwdata[`BIT_SPI_PARTIAL];
      end
      // only software moves these; enabling leaves them as they were
      if (wr_stat)
      begin
        slave_tx_select <= pwdata[`BIT_TX_SELECT];
        ack_out_ctrl    <= pwdata[`BIT_ACK_OUT];
        addr_wake_en    <= pwdata[`BIT_WAKE_EN];
      end
      if (wr && paddr == `OFS_OWN_ADDR)
        own_slave_address <= pwdata[7:0];
      if (wr && paddr == `OFS_TIMEOUT)
        bus_timeout_control <= pwdata[7:0];
    end
  end

  // ************************************************************
  // status flags set by the link
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_done_flag <= 1'b1;
      addr_hit_flag  <= 1'b0;
      bus_busy_flag  <= 1'b0;
      host_read_flag <= 1'b0;
      ack_in_flag    <= 1'b1;
    end
    else if (on_rise || !active)
    begin
      // defaults on enable, and held idle outside i2c mode
      xfer_done_flag <= 1'b1;
      addr_hit_flag  <= 1'b0;
      bus_busy_flag  <= 1'b0;
      host_read_flag <= 1'b0;
      ack_in_flag    <= 1'b1;
    end
    else
    begin
      if (start_det)
      begin
        bus_busy_flag <= 1'b1;
        addr_hit_flag <= 1'b0;
      end
      else if (stop_det)
        bus_busy_flag <= 1'b0;
      if (byte_begin)
        xfer_done_flag <= 1'b0;
      if (addr_done || rx_done || tx_done)
        xfer_done_flag <= 1'b1;
      if (match)
      begin
        addr_hit_flag  <= 1'b1;
        host_read_flag <= shreg[0];
      end
      if (ack_rise)
        ack_in_flag <= sda_f;
    end
  end

  // event pulse toward the module interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sim_event <= 1'b0;
    else
      sim_event <= match | rx_done | tx_done;
  end

  // ************************************************************
  // shared data register, no reset value
  // ************************************************************
  // a received byte beats a software write in the same cycle
  always_ff @(posedge pclk)
  begin
    if (rx_done)
      shift_data <= shreg;
    else if (wr_data)
      shift_data <= pwdata[7:0];
  end

  // ************************************************************
  // slave engine
  // ************************************************************
  // no clock stretching: transmit data must be in place before the
  // master clocks the byte out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= st_idle;
      shreg    <= 8'h00;
      bit_cnt  <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (!active)
    begin
      state    <= st_idle;
      bit_cnt  <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (start_det)
    begin
      state    <= st_addr;
      bit_cnt  <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_det)
    begin
      state    <= st_idle;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (state)
        st_idle, st_wait_stop:
          sda_oe_n <= 1'b1;
        st_addr, st_rx:
          if (scl_rise && bit_cnt != `BYTE_BITS)
          begin
            shreg   <= {shreg[6:0], sda_f}; // msb first
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == `BYTE_BITS)
          begin
            bit_cnt <= 4'h0;
            if (state == st_rx)
            begin
              state    <= st_rx_ack;
              sda_oe_n <= ack_out_ctrl;
            end
            else if (match)
            begin
              state    <= st_addr_ack;
              sda_oe_n <= 1'b0;
            end
            else
              state <= st_wait_stop;
          end
        st_addr_ack, st_rx_ack:
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (state == st_addr_ack && host_read_flag)
            begin
              state    <= st_tx;
              shreg    <= shift_data;
              sda_oe_n <= shift_data[7];
            end
            else
            begin
              state    <= st_rx;
              sda_oe_n <= 1'b1;
            end
          end
        st_tx:
          if (scl_fall)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
            begin
              state    <= st_tx_ack;
              sda_oe_n <= 1'b1;
            end
            else
            begin
              sda_oe_n <= shreg[6];
              shreg    <= {shreg[6:0], 1'b0};
            end
          end
        st_tx_ack:
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (!ack_in_flag)
            begin
              state    <= st_tx;
              shreg    <= shift_data;
              sda_oe_n <= shift_data[7];
            end
            else
              state <= st_wait_stop;
          end
      endcase
    end
  end

  // open drain: only ever pull low; scl is never held
  assign sda_out  = 1'b0;
  assign scl_out  = 1'b0;
  assign scl_oe_n = 1'b1;

  // ************************************************************
  // apb read data
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
    begin
      unique case (paddr)
        `OFS_MODE_CTRL:
          prdata <= {24'h0, op_mode, 1'b0, glitch_filter_sel, module_on, spi_partial_flag};
        `OFS_STATUS:
          prdata <= {24'h0, xfer_done_flag, addr_hit_flag, bus_busy_flag, slave_tx_select,
                     ack_out_ctrl, host_read_flag, addr_wake_en, ack_in_flag};
        `OFS_SHIFT_DATA: prdata <= {24'h0, shift_data};
        `OFS_OWN_ADDR:   prdata <= {24'h0, own_slave_address};
        `OFS_TIMEOUT:    prdata <= {24'h0, bus_timeout_control};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_idle_release: assert property (@(posedge pclk) disable iff (!presetn)
    !active |=> sda_oe_n) else $error("sda driven while inactive");
  chk_enable_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    on_rise |=> xfer_done_flag && ack_in_flag && !addr_hit_flag && !bus_busy_flag
    && !host_read_flag) else $error("flags not restored on enable");
  chk_enable_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    on_rise && !wr_stat |=> slave_tx_select == $past(slave_tx_select)
    && ack_out_ctrl == $past(ack_out_ctrl)) else $error("control bits lost on enable");
  chk_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    active && start_det && !on_rise |=> bus_busy_flag) else $error("start missed");
  chk_match_hit: assert property (@(posedge pclk) disable iff (!presetn)
    match && !on_rise |=> addr_hit_flag && sim_event) else $error("hit not set");
  chk_rw_capture: assert property (@(posedge pclk) disable iff (!presetn)
    match && !on_rise |=> host_read_flag == $past(shreg[0]) && state == st_addr_ack
    && !sda_oe_n) else $error("direction or ack wrong");
  chk_ack_sample: assert property (@(posedge pclk) disable iff (!presetn)
    ack_rise && !on_rise |=> ack_in_flag == $past(sda_f)) else $error("ack not sampled");
  chk_rx_store: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done |=> shift_data == $past(shreg) && xfer_done_flag) else $error("byte not stored");
  chk_spi_idle: assert property (@(posedge pclk) disable iff (!presetn)
    module_on && op_mode != `MODE_I2C_SLAVE |=> ##1 !bus_busy_flag && state == st_idle)
    else $error("engine busy in spi mode");

  cov_addr_match: cover property (@(posedge pclk) disable iff (!presetn) match);
  cov_rx_byte: cover property (@(posedge pclk) disable iff (!presetn) rx_done);
  cov_tx_nack: cover property (@(posedge pclk) disable iff (!presetn)
    ack_rise && sda_f);

endmodule : serial_module_i2c_slave
`default_nettype wire

// ### verification/i2c_host_model.sv
// i2c bus master model that drives scl and sda through open-drain releases
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int HALF = 10 // half scl period; 10 MHz clock suits fast mode
) (
  input  wire logic pclk,     // system clock
  input  wire logic sda_line, // resolved sda level
  output var  logic scl_drv,  // scl, 0 pulls low, 1 releases
  output var  logic sda_drv   // sda, 0 pulls low, 1 releases
);
  // both lines released at power up, the pull-ups hold them high
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // start: sda falls while scl stays high
  task automatic bus_start();
    sda_drv <= 1'b1;
    tick(HALF);
    scl_drv <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b0;
    tick(HALF);
    scl_drv <= 1'b0;
    tick(HALF);
  endtask : bus_start
  // data moves only while scl is low, two cycles after the fall, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(HALF);
    scl_drv <= 1'b1;
    tick(HALF);
    r = sda_line;
    scl_drv <= 1'b0;
    tick(2);
  endtask : bit_io
  // a byte msb first, then the ninth bit; the master always owns scl
  task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                      output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_bit, ack_seen);
  endtask : xfer
  // stop: sda rises while scl is high
  task automatic bus_stop();
    sda_drv <= 1'b0;
    tick(HALF);
    scl_drv <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b1;
    tick(HALF);
  endtask : bus_stop
endmodule : i2c_host_model
`default_nettype wire

// ### verification/serial_module_i2c_slave_test.sv
// self-checking bench of the i2c slave: apb register tasks and bus transfers
`include "i2c_slave_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_module_i2c_slave_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, sim_event;
  logic scl_drv, sda_drv, e, ak;
  logic [2:0] op_mode;
  logic [7:0] q, rx, events = 8'h00;
  int num_errors = 0, comparisons = 0;
  // open-drain wires with pull-ups: any party pulling low wins
  wire logic scl_line = scl_drv & (scl_oe_n | scl_out);
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  always #50 pclk = ~pclk;
  // count event pulses; each one stands for a single cycle
  always @(posedge pclk)
    if (sim_event === 1'b1)
      events <= events + 8'h01;
  serial_module_i2c_slave serial_module_i2c_slave_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sim_event(sim_event), .op_mode(op_mode));
  i2c_host_model i2c_host_model_i (.pclk(pclk), .sda_line(sda_line), .scl_drv(scl_drv),
    .sda_drv(sda_drv));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ************************************************************
  // apb master: request held until pready is seen high at an edge
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      num_errors++;
      close_out();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  // masked read so that only the bits a case speaks for are compared
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x,
                    input string name);
    apb(1'b0, a, 8'h00, q, e);
    check(name, q & m, x);
  endtask : rd
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_MODE_CTRL, 8'hFF, 8'hE0, "mode_reset");
    rd(`OFS_STATUS, 8'hFF, 8'h81, "status_reset");
    rd(`OFS_OWN_ADDR, 8'hFF, 8'h00, "addr_reset");
    apb(1'b0, 8'h14, 8'h00, q, e);
    check("unmapped_err", {7'h0, e}, 8'h01);
    wr(`OFS_OWN_ADDR, 8'hA5);
    rd(`OFS_OWN_ADDR, 8'hFF, 8'hA5, "own_addr");
    wr(`OFS_TIMEOUT, 8'hC5);
    rd(`OFS_TIMEOUT, 8'hFF, 8'hC5, "timeout_reg");
    // master writes one byte under each debounce code, 1x both ways
    for (int deb = 0; deb < 4; deb++)
    begin
      wr(`OFS_MODE_CTRL, 8'hC2 | 8'(deb << 2));
      i2c_host_model_i.bus_start();
      check("op_mode", {5'h0, op_mode}, 8'h06);
      rd(`OFS_STATUS, 8'h20, 8'h20, "busy_on_start");
      i2c_host_model_i.xfer(8'hA4, 1'b1, rx, ak);
      check("addr_ack", {7'h0, ak}, 8'h00);
      rd(`OFS_STATUS, 8'h44, 8'h40, "hit_and_dir");
      i2c_host_model_i.xfer(8'h30 + 8'(deb), 1'b1, rx, ak);
      check("data_ack", {7'h0, ak}, 8'h00);
      rd(`OFS_SHIFT_DATA, 8'hFF, 8'h30 + 8'(deb), "rx_byte");
      rd(`OFS_STATUS, 8'h80, 8'h80, "xfer_done");
      i2c_host_model_i.bus_stop();
      rd(`OFS_STATUS, 8'h20, 8'h00, "busy_on_stop");
    end
    // an address that differs from the own address in bit 1 is refused
    i2c_host_model_i.bus_start();
    i2c_host_model_i.xfer(8'hA6, 1'b1, rx, ak);
    check("foreign_nack", {7'h0, ak}, 8'h01);
    rd(`OFS_STATUS, 8'h40, 8'h00, "no_hit");
    i2c_host_model_i.bus_stop();
    // master reads: ack on the first byte, nack on the second
    wr(`OFS_SHIFT_DATA, 8'h96);
    wr(`OFS_STATUS, 8'h10);
    i2c_host_model_i.bus_start();
    i2c_host_model_i.xfer(8'hA5, 1'b1, rx, ak);
    check("read_addr_ack", {7'h0, ak}, 8'h00);
    rd(`OFS_STATUS, 8'h04, 8'h04, "host_read");
    i2c_host_model_i.xfer(8'hFF, 1'b0, rx, ak);
    check("tx_byte", rx, 8'h96);
    rd(`OFS_STATUS, 8'h01, 8'h00, "ack_in_clear");
    i2c_host_model_i.xfer(8'hFF, 1'b1, rx, ak);
    rd(`OFS_STATUS, 8'h01, 8'h01, "ack_in_set");
    i2c_host_model_i.bus_stop();
    // enable dropped while the slave pulls sda for bit 7, then raised again
    wr(`OFS_SHIFT_DATA, 8'h69);
    i2c_host_model_i.bus_start();
    i2c_host_model_i.xfer(8'hA5, 1'b1, rx, ak);
    i2c_host_model_i.tick(8);
    check("driving_sda", {7'h0, sda_oe_n}, 8'h00);
    wr(`OFS_MODE_CTRL, 8'hC4);
    repeat (2) @(negedge pclk);
    check("released_sda", {7'h0, sda_oe_n}, 8'h01);
    wr(`OFS_MODE_CTRL, 8'hC6);
    rd(`OFS_STATUS, 8'hFF, 8'h91, "enable_rise");
    i2c_host_model_i.bus_stop();
    // spi slave mode leaves the i2c engine deaf
    wr(`OFS_MODE_CTRL, 8'hA2);
    i2c_host_model_i.bus_start();
    i2c_host_model_i.xfer(8'hA4, 1'b1, rx, ak);
    check("spi_no_ack", {7'h0, ak}, 8'h01);
    rd(`OFS_STATUS, 8'h60, 8'h00, "spi_idle_flags");
    i2c_host_model_i.bus_stop();
    // six matches, four received and two sent bytes
    check("event_count", events, 8'h0C);
    check("fixed_pins", {5'h0, scl_oe_n, scl_out, sda_out}, 8'h04);
    check("pready", {7'h0, pready}, 8'h01);
    close_out();
  end
endmodule : serial_module_i2c_slave_test
`default_nettype wire
